// ===== verilog/aic_i2c_slave.sv
// two-wire serial slave interface of the delta-sigma converter
`timescale 1ns/10ps
`default_nettype none
module aic_i2c_slave #(
	parameter int unsigned TMO_NORMAL     = aic_pkg::TMO_NORMAL_PERIODS,
	parameter int unsigned TMO_TURBO      = aic_pkg::TMO_TURBO_PERIODS,
	parameter int unsigned DIV_NORMAL     = aic_pkg::MOD_DIV_NORMAL,
	parameter int unsigned DIV_TURBO      = aic_pkg::MOD_DIV_TURBO,
	parameter int unsigned RELEASE_CYCLES = aic_pkg::READY_RELEASE_CYCLES
) (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_b,
	input  wire logic                                scl_in,
	input  wire logic                                sda_in,
	output var  logic                                sda_out,
	output var  logic                                sda_oe,
	input  wire logic [1:0]                          addr_select_low_pin,
	input  wire logic [1:0]                          addr_select_high_pin,
	input  wire logic                                turbo_mode,
	input  wire logic                                continuous_mode,
	input  wire logic                                result_valid,
	input  wire logic signed [aic_pkg::RAW_W-1:0]    result_raw,
	output var  logic [7:0]                          rx_byte,
	output var  logic                                rx_valid,
	output var  logic                                soft_reset,
	output var  logic                                bus_busy,
	output var  logic                                timeout_reset,
	output var  logic                                conversion_ready_n_out,
	output var  logic                                conversion_ready_n_oe
);
	import aic_pkg::*;

	initial begin
		if (TMO_NORMAL < 2 || TMO_NORMAL > 32767 || TMO_TURBO < 2 || TMO_TURBO > 32767)
			$error("timeout period count out of range");
		if (DIV_NORMAL < 2 || DIV_NORMAL > 65535 || DIV_TURBO < 2 || DIV_TURBO > 65535)
			$error("modulator divider out of range");
	end

	typedef struct packed {
		logic [2:0][PIN_W-1:0] pins_s;
		logic [PIN_W-1:0]      pins;
		logic [PIN_W-1:0]      pins_d;
		aic_state_t            st;
		logic [3:0]            bcnt;
		logic [7:0]            shift;
		logic                  rw;
		logic                  gc;
		logic                  gc_first;
		logic                  nack;
		logic [6:0]            my_addr;
		logic [15:0]           hold;
		logic [15:0]           tx;
		logic                  sda_oe;
		logic [7:0]            rx_byte;
		logic                  rx_valid;
		logic                  soft_reset;
		logic                  latched;
		logic                  new_result;
		logic                  busy;
		logic [15:0]           div;
		logic                  tick;
		logic [14:0]           tmo;
		logic                  timeout;
		logic                  rdy_oe;
	} aic_core_state_t;

	aic_core_state_t s, next_s;
	aic_ready_if     rdy_if ();

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [6:0] pin_addr;

	assign scl        = s.pins[PIN_SCL];
	assign sda        = s.pins[PIN_SDA];
	assign scl_rise   = scl && !s.pins_d[PIN_SCL];
	assign scl_fall   = !scl && s.pins_d[PIN_SCL];
	assign start_cond = scl && s.pins_d[PIN_SCL] && !sda && s.pins_d[PIN_SDA];
	assign stop_cond  = scl && s.pins_d[PIN_SCL] && sda && !s.pins_d[PIN_SDA];
	// strap codes decide the low address bits
	assign pin_addr   = {ADDR_PREFIX, s.pins[PIN_AHI +: 2], s.pins[PIN_ALO +: 2]};

	always_comb begin
		next_s            = s;
		next_s.rx_valid   = 1'b0;
		next_s.soft_reset = 1'b0;
		next_s.latched    = 1'b0;
		next_s.new_result = 1'b0;
		next_s.timeout    = 1'b0;
		next_s.tick       = 1'b0;
		next_s.rdy_oe     = rdy_if.ready_oe;

		// pins pass three flops; a level counts once the last two agree
		next_s.pins_s = {s.pins_s[1:0], {addr_select_high_pin, addr_select_low_pin, scl_in, sda_in}};
		for (int i = 0; i < PIN_W; i++) begin
			if (s.pins_s[1][i] == s.pins_s[2][i])
				next_s.pins[i] = s.pins_s[2][i];
		end
		next_s.pins_d = s.pins;

		// modulator period enable; turbo halves the period
		if (s.div >= 16'((turbo_mode ? DIV_TURBO : DIV_NORMAL) - 1)) begin
			next_s.div  = 16'h0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.div = s.div + 16'h0001;
		end

		if (result_valid) begin
			next_s.hold       = aic_saturate(result_raw);
			next_s.new_result = 1'b1;
		end

		// the serial data line is only ever driven low
		unique case (s.st)
			ST_IDLE: begin
				next_s.sda_oe = 1'b0;
			end
			ST_ADDR: begin
				if (scl_rise) begin
					next_s.shift = {s.shift[6:0], sda};
					next_s.bcnt  = s.bcnt + 4'h1;
				end
				if (scl_fall && s.bcnt == 4'h0)
					next_s.my_addr = pin_addr;
				if (scl_fall && s.bcnt == BYTE_BITS) begin
					next_s.rw = s.shift[0];
					if (s.shift[7:1] == s.my_addr) begin
						next_s.sda_oe = 1'b1;
						next_s.gc     = 1'b0;
						next_s.st     = ST_ADDR_ACK;
						if (s.shift[0]) begin
							next_s.tx      = s.hold;
							next_s.latched = 1'b1;
						end
					end else if (s.shift[7:1] == GC_ADDR && !s.shift[0]) begin
						next_s.sda_oe   = 1'b1;
						next_s.gc       = 1'b1;
						next_s.gc_first = 1'b1;
						next_s.st       = ST_ADDR_ACK;
					end else begin
						next_s.st = ST_IGNORE;
					end
				end
			end
			ST_ADDR_ACK: begin
				if (scl_fall) begin
					next_s.bcnt = 4'h0;
					if (s.rw) begin
						next_s.sda_oe = !s.tx[15];
						next_s.st     = ST_TX;
					end else begin
						next_s.sda_oe = 1'b0;
						next_s.st     = ST_RX;
					end
				end
			end
			ST_RX: begin
				if (scl_rise) begin
					next_s.shift = {s.shift[6:0], sda};
					next_s.bcnt  = s.bcnt + 4'h1;
				end
				if (scl_fall && s.bcnt == BYTE_BITS) begin
					next_s.sda_oe = 1'b1;
					next_s.st     = ST_RX_ACK;
					if (s.gc) begin
						next_s.gc_first = 1'b0;
						if (s.gc_first && s.shift == GC_RESET_BYTE)
							next_s.soft_reset = 1'b1;
					end else begin
						next_s.rx_byte  = s.shift;
						next_s.rx_valid = 1'b1;
					end
				end
			end
			ST_RX_ACK: begin
				if (scl_fall) begin
					next_s.sda_oe = 1'b0;
					next_s.bcnt   = 4'h0;
					next_s.st     = ST_RX;
				end
			end
			ST_TX: begin
				if (scl_rise)
					next_s.bcnt = s.bcnt + 4'h1;
				if (scl_fall) begin
					if (s.bcnt == BYTE_BITS) begin
						next_s.sda_oe = 1'b0;
						next_s.st     = ST_TX_ACK;
						next_s.tx     = {s.tx[14:0], 1'b1};
					end else begin
						next_s.tx     = {s.tx[14:0], 1'b1};
						next_s.sda_oe = !s.tx[14];
					end
				end
			end
			ST_TX_ACK: begin
				// master acks a byte to read on; a nack ends the read
				if (scl_rise)
					next_s.nack = sda;
				if (scl_fall) begin
					next_s.bcnt = 4'h0;
					if (s.nack) begin
						next_s.st = ST_IGNORE;
					end else begin
						next_s.sda_oe = !s.tx[15];
						next_s.st     = ST_TX;
					end
				end
			end
			ST_IGNORE: begin
				next_s.sda_oe = 1'b0;
			end
		endcase

		// idle limit counted in modulator periods
		if (s.st == ST_IDLE || scl_rise || scl_fall) begin
			next_s.tmo = 15'h0000;
		end else if (s.tick) begin
			if (s.tmo >= 15'((turbo_mode ? TMO_TURBO : TMO_NORMAL) - 1)) begin
				next_s.tmo     = 15'h0000;
				next_s.timeout = 1'b1;
				next_s.st      = ST_IDLE;
				next_s.sda_oe  = 1'b0;
				next_s.busy    = 1'b0;
			end else begin
				next_s.tmo = s.tmo + 15'h0001;
			end
		end

		// start and stop override any bit in flight
		if (start_cond) begin
			next_s.st      = ST_ADDR;
			next_s.bcnt    = 4'h0;
			next_s.sda_oe  = 1'b0;
			next_s.busy    = 1'b1;
			next_s.my_addr = pin_addr;
			next_s.tmo     = 15'h0000;
		end else if (stop_cond) begin
			next_s.st     = ST_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.busy   = 1'b0;
		end

		// general-call reset clears the held result and the transmit word
		if (s.soft_reset) begin
			next_s.hold = '0;
			next_s.tx   = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			s <= '0;
		else
			s <= next_s;
	end

	assign rdy_if.new_result = s.new_result;
	assign rdy_if.latched    = s.latched;
	assign rdy_if.soft_reset = s.soft_reset;
	assign rdy_if.continuous = continuous_mode;

	aic_ready #(
		.RELEASE_CYCLES (RELEASE_CYCLES)
	) u_ready (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.rdy     (rdy_if.ready)
	);

	// no clock output exists: the master owns every clock pulse
	// rates to 1 Mbps leave over 40 samples per clock phase
	assign sda_out                = 1'b0;
	assign sda_oe                 = s.sda_oe;
	assign rx_byte                = s.rx_byte;
	assign rx_valid               = s.rx_valid;
	assign soft_reset             = s.soft_reset;
	assign bus_busy               = s.busy;
	assign timeout_reset          = s.timeout;
	assign conversion_ready_n_out = 1'b0;
	assign conversion_ready_n_oe  = s.rdy_oe;
endmodule : aic_i2c_slave
`default_nettype wire

// ===== verilog/aic_pkg.sv
// constants and types shared by the converter serial slave interface
`default_nettype none
package aic_pkg;
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned MOD_HZ_NORMAL = 256_000;
	localparam int unsigned MOD_HZ_TURBO  = 512_000;
	localparam int unsigned MOD_DIV_NORMAL = CLK_HZ / MOD_HZ_NORMAL;
	localparam int unsigned MOD_DIV_TURBO  = CLK_HZ / MOD_HZ_TURBO;
	localparam int unsigned TMO_NORMAL_PERIODS = 14000;
	localparam int unsigned TMO_TURBO_PERIODS  = 28000;
	localparam int unsigned READY_RELEASE_CYCLES = 64;

	localparam logic [2:0] ADDR_PREFIX   = 3'h4;
	localparam logic [6:0] GC_ADDR       = 7'h00;
	localparam logic [7:0] GC_RESET_BYTE = 8'h06;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	localparam logic [1:0] TIE_GROUND = 2'h0;
	localparam logic [1:0] TIE_SUPPLY = 2'h1;
	localparam logic [1:0] TIE_SDA    = 2'h2;
	localparam logic [1:0] TIE_SCL    = 2'h3;

	localparam int unsigned PIN_SDA = 0;
	localparam int unsigned PIN_SCL = 1;
	localparam int unsigned PIN_ALO = 2;
	localparam int unsigned PIN_AHI = 4;
	localparam int unsigned PIN_W   = 6;

	localparam int unsigned RAW_W = 18;
	localparam logic signed [RAW_W-1:0] RAW_MAX = 18'sh07FFF;
	localparam logic signed [RAW_W-1:0] RAW_MIN = -18'sh08000;
	localparam logic [15:0] CODE_MAX = 16'h7FFF;
	localparam logic [15:0] CODE_MIN = 16'h8000;
	localparam logic [15:0] IDLE_WORD = 16'hFFFF;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
	} aic_state_t;

	// raw sample counts one code step per unit
	function automatic logic [15:0] aic_saturate(input logic signed [RAW_W-1:0] raw);
		if (raw >= RAW_MAX)
			return CODE_MAX;
		else if (raw <= RAW_MIN)
			return CODE_MIN;
		else
			return raw[15:0];
	endfunction : aic_saturate
endpackage : aic_pkg
`default_nettype wire

// ===== verilog/aic_ready_if.sv
// handshake between serial core and conversion-ready driver
`timescale 1ns/10ps
`default_nettype none
interface aic_ready_if;
	logic new_result;
	logic latched;
	logic soft_reset;
	logic continuous;
	logic ready_oe;
	modport core  (output new_result, output latched, output soft_reset, output continuous, input ready_oe);
	modport ready (input new_result, input latched, input soft_reset, input continuous, output ready_oe);
endinterface : aic_ready_if
`default_nettype wire

// ===== verilog/aic_ready.sv
// open-drain conversion-ready driver with release pulse
`timescale 1ns/10ps
`default_nettype none
module aic_ready #(
	parameter int unsigned RELEASE_CYCLES = aic_pkg::READY_RELEASE_CYCLES
) (
	input  wire logic  sys_clk,
	input  wire logic  rst_b,
	aic_ready_if.ready rdy
);
	import aic_pkg::*;

	initial begin
		if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > 65535)
			$error("release width out of range");
	end

	typedef struct packed {
		logic        ready_oe;
		logic        releasing;
		logic [15:0] cnt;
	} aic_rdy_state_t;

	aic_rdy_state_t r, next_r;

	always_comb begin
		next_r = r;
		if (r.releasing) begin
			if (r.cnt == 16'h0000) begin
				next_r.releasing = 1'b0;
				next_r.ready_oe  = 1'b1;
			end else begin
				next_r.cnt = r.cnt - 16'h0001;
			end
		end
		if (rdy.latched || rdy.soft_reset) begin
			next_r.ready_oe  = 1'b0;
			next_r.releasing = 1'b0;
		end
		// a new result beats a latch in the same cycle; only a soft reset in that cycle drops it
		if (rdy.new_result && !rdy.soft_reset) begin
			if (r.ready_oe && rdy.continuous && !rdy.latched) begin
				next_r.ready_oe  = 1'b0;
				next_r.releasing = 1'b1;
				next_r.cnt       = 16'(RELEASE_CYCLES - 1);
			end else begin
				next_r.ready_oe  = 1'b1;
				next_r.releasing = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign rdy.ready_oe = r.ready_oe;
endmodule : aic_ready
`default_nettype wire

// ===== dv/aic_i2c_slave_properties.sv
// concurrent checks on the serial slave top-level ports
`timescale 1ns/10ps
`default_nettype none
module aic_i2c_slave_properties #(
	parameter int unsigned TMO_TURBO = 8,
	parameter int unsigned DIV_TURBO = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic continuous_mode,
	input wire logic result_valid,
	input wire logic rx_valid,
	input wire logic soft_reset,
	input wire logic bus_busy,
	input wire logic timeout_reset,
	input wire logic conversion_ready_n_out,
	input wire logic conversion_ready_n_oe
);
	localparam int unsigned QMIN = (TMO_TURBO - 1) * DIV_TURBO;
	int unsigned quiet;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// cycles since the clock pin last moved; turbo gives the shorter limit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			quiet <= 0;
		else
			quiet <= $changed(scl_in) ? 0 : quiet + 1;
	end
	a_open_drain_only: assert property (sda_out == 1'h0 && conversion_ready_n_out == 1'h0)
		else $error("pin value not low");
	a_data_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed while clock high");
	a_drive_after_fall: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 8))
		else $error("data driven long after clock fall");
	a_busy_at_start: assert property (scl_in && $fell(sda_in) |-> ##[1:8] bus_busy)
		else $error("start not marked busy");
	a_free_at_stop: assert property (scl_in && $rose(sda_in) |-> ##[1:8] !bus_busy)
		else $error("stop left bus busy");
	a_byte_in_frame: assert property (rx_valid |-> bus_busy)
		else $error("byte outside transaction");
	a_ready_on_result: assert property (result_valid && !(continuous_mode && conversion_ready_n_oe)
		|-> ##3 conversion_ready_n_oe)
		else $error("ready not pulled low");
	a_release_pulse: assert property (result_valid && continuous_mode && conversion_ready_n_oe
		|-> ##[1:3] !conversion_ready_n_oe [*4] ##1 conversion_ready_n_oe)
		else $error("release pulse wrong");
	a_reset_clears_ready: assert property (soft_reset |-> ##[0:2] !conversion_ready_n_oe)
		else $error("reset kept ready");
	a_timeout_idles: assert property (timeout_reset |-> ##[0:1] (!bus_busy && !sda_oe))
		else $error("timeout left interface busy");
	a_timeout_quiet: assert property (timeout_reset |-> quiet >= QMIN)
		else $error("timeout too early");
endmodule : aic_i2c_slave_properties
bind aic_i2c_slave aic_i2c_slave_properties #(.TMO_TURBO(TMO_TURBO), .DIV_TURBO(DIV_TURBO))
	aic_i2c_slave_properties_i (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .continuous_mode(continuous_mode), .result_valid(result_valid),
	.rx_valid(rx_valid), .soft_reset(soft_reset), .bus_busy(bus_busy), .timeout_reset(timeout_reset),
	.conversion_ready_n_out(conversion_ready_n_out), .conversion_ready_n_oe(conversion_ready_n_oe));
`default_nettype wire

// ===== dv/aic_i2c_master_model.sv
// behavioural two-wire bus master facing the slave
`timescale 1ns/10ps
`default_nettype none
module aic_i2c_master_model (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic m_oe
);
	// only this side makes clock pulses; idle clock stays high
	initial begin
		scl = 1'h1;
		m_oe = 1'h0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : w
	// fresh or repeated start, data falls with clock high
	task automatic start();
		w(32);
		m_oe = 1'h0;
		w(32);
		scl = 1'h1;
		w(32);
		m_oe = 1'h1;
		w(32);
		scl = 1'h0;
	endtask : start
	// data rises with clock high
	task automatic stop();
		w(32);
		m_oe = 1'h1;
		w(32);
		scl = 1'h1;
		w(32);
		m_oe = 1'h0;
		w(32);
	endtask : stop
	// data set mid-low, one pulse per bit, 126 cycles keeps under 1 Mbps
	task automatic bit_x(input logic b, output logic r);
		w(30);
		m_oe = !b;
		w(32);
		scl = 1'h1;
		w(64);
		r = sda_line;
		scl = 1'h0;
	endtask : bit_x
	// msb first, ninth pulse carries the ack of the receiver
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic ar);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(ak, ar);
	endtask : xfer
endmodule : aic_i2c_master_model
`default_nettype wire

// ===== dv/aic_i2c_slave_tb_top.sv
// self-checking bench for the converter serial slave interface
`timescale 1ns/10ps
`default_nettype none
module aic_i2c_slave_tb_top;
	import aic_pkg::*;
	localparam int TN = 4, TT = 8, DN = 64, DT = 16, REL = 4;
	logic                    sys_clk, rst_b, scl, m_oe, sda_line, sda_out, sda_oe, turbo, cont, rv, ar;
	logic                    rx_valid, soft_reset, bus_busy, tmo, rdy_out, rdy_oe;
	logic [1:0]              alo, ahi;
	logic signed [RAW_W-1:0] raw;
	logic [7:0]              rx_byte, rx_last, q;
	int                      fail_count = 0, n_checks = 0, n_rx = 0, n_sr = 0, n_to = 0;
	assign sda_line = !(sda_oe | m_oe); // pull-up gives the high level
	aic_i2c_slave #(.TMO_NORMAL(TN), .TMO_TURBO(TT), .DIV_NORMAL(DN), .DIV_TURBO(DT), .RELEASE_CYCLES(REL))
		aic_i2c_slave_i (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_select_low_pin(alo), .addr_select_high_pin(ahi), .turbo_mode(turbo),
		.continuous_mode(cont), .result_valid(rv), .result_raw(raw), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.soft_reset(soft_reset), .bus_busy(bus_busy), .timeout_reset(tmo), .conversion_ready_n_out(rdy_out),
		.conversion_ready_n_oe(rdy_oe));
	aic_i2c_master_model aic_i2c_master_model_i (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .m_oe(m_oe));
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (rx_valid === 1'h1) begin
			n_rx++;
			rx_last = rx_byte;
		end
		if (soft_reset === 1'h1) n_sr++;
		if (tmo === 1'h1) n_to++;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic addr(input logic [6:0] a, input logic rd);
		aic_i2c_master_model_i.start();
		aic_i2c_master_model_i.xfer({a, rd}, 1'h1, q, ar);
	endtask : addr
	task automatic pulse(input logic signed [RAW_W-1:0] v);
		raw = v;
		rv = 1'h1;
		tick(1);
		rv = 1'h0;
	endtask : pulse
	// every pin tie pair, then a stranger address that must stay silent
	task automatic t_addr();
		int n0;
		for (int i = 0; i < 16; i++) begin
			{ahi, alo} = i[3:0];
			addr({3'h4, i[3:0]}, 1'h0);
			chk(ar, 1'h0);
			chk(bus_busy, 1'h1);
			aic_i2c_master_model_i.stop();
			chk(bus_busy, 1'h0);
		end
		n0 = n_rx;
		addr(7'h41, 1'h0);
		chk(ar, 1'h1);
		aic_i2c_master_model_i.xfer(8'h5A, 1'h1, q, ar);
		chk(ar, 1'h1);
		chk(n_rx - n0, 0);
		aic_i2c_master_model_i.stop();
	endtask : t_addr
	task automatic t_write();
		ahi = TIE_SDA;
		alo = TIE_SUPPLY;
		addr(7'h49, 1'h0);
		aic_i2c_master_model_i.xfer(8'hA5, 1'h1, q, ar);
		chk(ar, 1'h0);
		chk(rx_last, 8'hA5);
		aic_i2c_master_model_i.xfer(8'h3C, 1'h1, q, ar);
		chk(ar, 1'h0);
		chk(rx_last, 8'h3C);
		aic_i2c_master_model_i.stop();
	endtask : t_write
	task automatic t_read(input logic signed [RAW_W-1:0] v, input logic [15:0] e);
		logic [7:0] hi;
		pulse(v);
		tick(4);
		chk(rdy_oe, 1'h1);
		addr(7'h49, 1'h1);
		chk(ar, 1'h0);
		chk(rdy_oe, 1'h0);
		aic_i2c_master_model_i.xfer(8'hFF, 1'h0, hi, ar);
		aic_i2c_master_model_i.xfer(8'hFF, 1'h1, q, ar);
		chk({hi, q}, e);
		aic_i2c_master_model_i.stop();
	endtask : t_read
	task automatic t_cont();
		int n;
		cont = 1'h1;
		pulse(18'sh00010);
		tick(4);
		pulse(18'sh00020);
		n = 0;
		for (int i = 0; i < 12; i++) begin
			tick(1);
			if (rdy_oe === 1'h0) n++;
		end
		chk(n, REL);
		chk(rdy_oe, 1'h1);
		cont = 1'h0;
	endtask : t_cont
	// 07h must not reset, 06h must; a read to the call address is refused
	task automatic t_gc();
		int n0;
		n0 = n_sr;
		for (int k = 0; k < 2; k++) begin
			addr(7'h00, 1'h0);
			chk(ar, 1'h0);
			aic_i2c_master_model_i.xfer(8'h07 - k[7:0], 1'h1, q, ar);
			chk(ar, 1'h0);
			aic_i2c_master_model_i.stop();
			chk(n_sr - n0, k);
		end
		chk(rdy_oe, 1'h0);
		addr(7'h00, 1'h1);
		chk(ar, 1'h1);
		aic_i2c_master_model_i.stop();
	endtask : t_gc
	// stall with clock low mid-frame, then recover with a fresh start
	task automatic t_tmo();
		int n, n0, t, lo;
		for (int k = 0; k < 2; k++) begin
			turbo = k[0];
			t = k ? TT * DT : TN * DN;
			lo = t - (k ? DT : DN);
			addr(7'h49, 1'h0);
			n0 = n_to;
			n = 0;
			while (n_to == n0 && n < 400) begin
				tick(1);
				n++;
			end
			chk(n >= lo && n <= t + 8, 1'h1);
			chk(bus_busy, 1'h0);
			addr(7'h49, 1'h0);
			chk(ar, 1'h0);
			aic_i2c_master_model_i.stop();
		end
		turbo = 1'h0;
	endtask : t_tmo
	logic signed [RAW_W-1:0] rtab [8] = '{18'sh00001, 18'sh00000, 18'sh3FFFF, 18'sh07FFF, 18'sh08000,
		18'sh38000, 18'sh37FFF, 18'sh07FFE};
	logic [15:0] etab [8] = '{16'h0001, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000, 16'h7FFE};
	initial begin
		rst_b = 1'h0;
		{turbo, cont, rv, alo, ahi} = '0;
		raw = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		rst_b = 1'h1;
		tick(6);
		t_addr();
		t_write();
		for (int i = 0; i < 8; i++) t_read(rtab[i], etab[i]);
		t_cont();
		t_gc();
		t_tmo();
		finish_test();
	end
	// whole run needs roughly 70000 cycles
	initial begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		finish_test();
	end
endmodule : aic_i2c_slave_tb_top
`default_nettype wire
